// >>> hw/isoi_core.sv
// Executes increment-skip-if-zero and the two inclusive OR instructions.
// Assumes the register file answers a read address combinationally and
// that the fetch unit presents the next instruction word at each Q1.
// Functional notes
// - Increment file, result to W or file
// - Zero result: skip next, two cycles
// - Nonzero result: next runs, one cycle
// - OR literal with working register
// - OR literal result to W, Z updated
// - OR W with file, chosen destination
// - Four quarters: decode, read, process, write
`timescale 1ns/10ps
module isoi_core
	import isoi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [13:0] instr,
	input wire logic [7:0] file_rdata,
	output logic [6:0] file_addr,
	output logic [7:0] file_wdata,
	output logic file_we,
	output logic [7:0] w_reg,
	output logic zero_flag,
	output logic zero_we,
	output logic pc_advance,
	output logic cycle_q4,
	output logic no_operation_cycle
);
	isoi_phase_t phase, next_phase;
	isoi_op_t op, next_op;
	logic [13:0] ir, next_ir;
	logic [7:0] opnd, next_opnd;
	logic [7:0] res, next_res;
	logic res_zero, next_res_zero;
	logic skip_pend, next_skip_pend;
	logic nop_cyc, next_nop_cyc;
	logic [6:0] next_file_addr;
	logic [7:0] next_file_wdata, next_w_reg;
	logic next_file_we, next_zero_flag, next_zero_we;
	logic next_pc_advance, next_cycle_q4;
	logic [7:0] alu_res;
	logic alu_zero;
	logic dest_file;

	assign dest_file = ir[ISOI_DEST_BIT];

	isoi_alu u_alu (
		.op(op),
		.w_val(w_reg),
		.file_val(opnd),
		.lit_val(ir[ISOI_DW-1:0]),
		.result(alu_res),
		.is_zero(alu_zero)
	);

	// Quarter sequencing and per-quarter work
	always_comb begin
		next_phase = phase;
		next_op = op;
		next_ir = ir;
		next_opnd = opnd;
		next_res = res;
		next_res_zero = res_zero;
		next_skip_pend = skip_pend;
		next_nop_cyc = nop_cyc;
		next_file_addr = file_addr;
		next_file_wdata = file_wdata;
		next_w_reg = w_reg;
		next_file_we = 1'b0;
		next_zero_flag = zero_flag;
		next_zero_we = 1'b0;
		next_pc_advance = 1'b0;
		next_cycle_q4 = 1'b0;
		case (phase)
			ISOI_Q1: begin
				next_phase = ISOI_Q2;
				next_ir = instr;
				next_file_addr = instr[ISOI_AW-1:0];
				// A pending skip turns this fetched word into a dead cycle
				next_nop_cyc = skip_pend;
				next_skip_pend = 1'b0;
				if (skip_pend)
					next_op = ISOI_OP_NONE;
				else if (instr[ISOI_OP_HI:ISOI_OP_LO] == ISOI_OP_INC_SKIP)
					next_op = ISOI_OP_INC;
				else if (instr[ISOI_OP_HI:ISOI_OP_LO] == ISOI_OP_OR_LIT)
					next_op = ISOI_OP_ORL;
				else if (instr[ISOI_OP_HI:ISOI_OP_LO] == ISOI_OP_OR_FILE)
					next_op = ISOI_OP_ORF;
				else
					next_op = ISOI_OP_NONE;
			end
			ISOI_Q2: begin
				next_phase = ISOI_Q3;
				next_opnd = file_rdata;
			end
			ISOI_Q3: begin
				next_phase = ISOI_Q4;
				next_res = alu_res;
				next_res_zero = alu_zero;
			end
			ISOI_Q4: begin
				next_phase = ISOI_Q1;
				next_cycle_q4 = 1'b1;
				next_pc_advance = 1'b1;
				next_file_wdata = res;
				case (op)
					ISOI_OP_INC: begin
						// Flags untouched by the increment
						if (dest_file)
							next_file_we = 1'b1;
						else
							next_w_reg = res;
						next_skip_pend = res_zero;
					end
					ISOI_OP_ORL: begin
						next_w_reg = res;
						next_zero_flag = res_zero;
						next_zero_we = 1'b1;
					end
					ISOI_OP_ORF: begin
						if (dest_file)
							next_file_we = 1'b1;
						else
							next_w_reg = res;
						next_zero_flag = res_zero;
						next_zero_we = 1'b1;
					end
					default: begin
						next_w_reg = w_reg;
					end
				endcase
			end
			default: next_phase = ISOI_Q1;
		endcase
	end

	// State registers; reset is not documented, so a clean Q1 start is used
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			phase <= ISOI_Q1;
			op <= ISOI_OP_NONE;
			ir <= '0;
			opnd <= ISOI_ZERO;
			res <= ISOI_ZERO;
			res_zero <= 1'b0;
			skip_pend <= 1'b0;
			nop_cyc <= 1'b0;
			file_addr <= '0;
			file_wdata <= ISOI_ZERO;
			w_reg <= ISOI_W_RESET;
			file_we <= 1'b0;
			zero_flag <= 1'b0;
			zero_we <= 1'b0;
			pc_advance <= 1'b0;
			cycle_q4 <= 1'b0;
		end else begin
			phase <= next_phase;
			op <= next_op;
			ir <= next_ir;
			opnd <= next_opnd;
			res <= next_res;
			res_zero <= next_res_zero;
			skip_pend <= next_skip_pend;
			nop_cyc <= next_nop_cyc;
			file_addr <= next_file_addr;
			file_wdata <= next_file_wdata;
			w_reg <= next_w_reg;
			file_we <= next_file_we;
			zero_flag <= next_zero_flag;
			zero_we <= next_zero_we;
			pc_advance <= next_pc_advance;
			cycle_q4 <= next_cycle_q4;
		end
	end

	assign no_operation_cycle = nop_cyc;

	// Checks
	sequence s_inc_zero;
		phase == ISOI_Q4 && op == ISOI_OP_INC && res_zero;
	endsequence
	sequence s_dead_cycle;
		(phase == ISOI_Q1) ##1 (nop_cyc && op == ISOI_OP_NONE)[*4];
	endsequence

	a_skip_nop_cycle: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_inc_zero |-> ##1 s_dead_cycle) else $error("skip did not kill next");
	a_no_skip_next: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase == ISOI_Q4 && op == ISOI_OP_INC && !res_zero) |=> ##1 !nop_cyc)
		else $error("nonzero increment skipped");
	a_inc_to_w: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase == ISOI_Q4 && op == ISOI_OP_INC && !dest_file)
		|=> w_reg == $past(opnd) + ISOI_ONE && !file_we)
		else $error("increment to W wrong");
	a_inc_to_file: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase == ISOI_Q4 && op == ISOI_OP_INC && dest_file)
		|=> file_we && file_wdata == $past(opnd) + ISOI_ONE)
		else $error("increment to file wrong");
	a_or_literal: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase == ISOI_Q3 && op == ISOI_OP_ORL)
		|=> ##1 w_reg == ($past(w_reg, 2) | $past(ir[7:0], 2)))
		else $error("OR literal result wrong");
	a_orl_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase == ISOI_Q4 && op == ISOI_OP_ORL)
		|=> zero_we && zero_flag == (w_reg == ISOI_ZERO))
		else $error("OR literal zero flag wrong");
	a_orf_file: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase == ISOI_Q4 && op == ISOI_OP_ORF && dest_file)
		|=> file_we && file_wdata == ($past(w_reg) | $past(opnd)))
		else $error("OR file result wrong");
	a_inc_flags_kept: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase == ISOI_Q4 && op == ISOI_OP_INC) |=> !zero_we && $stable(zero_flag))
		else $error("increment touched zero flag");
	a_quarter_order: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase == ISOI_Q1) |=> phase == ISOI_Q2 ##1 phase == ISOI_Q3
		##1 phase == ISOI_Q4 ##1 phase == ISOI_Q1)
		else $error("quarter order broken");
endmodule // isoi_core

// >>> hw/isoi_pkg.sv
// Package for the increment-skip / OR instruction execution block.
// Assumes a 14-bit instruction word and an 8-bit data path.
package isoi_pkg;
	localparam int ISOI_IW = 14;
	localparam int ISOI_DW = 8;
	localparam int ISOI_AW = 7;
	// Opcode fields, bits 13:8
	localparam logic [5:0] ISOI_OP_INC_SKIP = 6'h0F;
	localparam logic [5:0] ISOI_OP_OR_LIT = 6'h38;
	localparam logic [5:0] ISOI_OP_OR_FILE = 6'h04;
	localparam int ISOI_OP_HI = 13;
	localparam int ISOI_OP_LO = 8;
	localparam int ISOI_DEST_BIT = 7;
	localparam logic [7:0] ISOI_ZERO = 8'h00;
	localparam logic [7:0] ISOI_ONE = 8'h01;
	localparam logic [7:0] ISOI_W_RESET = 8'h00;
	// Quarter phase one-hot codes
	typedef enum logic [3:0] {
		ISOI_Q1 = 4'b0001,
		ISOI_Q2 = 4'b0010,
		ISOI_Q3 = 4'b0100,
		ISOI_Q4 = 4'b1000
	} isoi_phase_t;
	typedef enum logic [3:0] {
		ISOI_OP_NONE = 4'b0001,
		ISOI_OP_INC = 4'b0010,
		ISOI_OP_ORL = 4'b0100,
		ISOI_OP_ORF = 4'b1000
	} isoi_op_t;
endpackage

// >>> hw/isoi_alu.sv
// Combinational data unit for the three instructions.
// Assumes operands are stable during the process-data quarter.
`timescale 1ns/10ps
module isoi_alu
	import isoi_pkg::*;
(
	input wire isoi_op_t op,
	input wire logic [7:0] w_val,
	input wire logic [7:0] file_val,
	input wire logic [7:0] lit_val,
	output logic [7:0] result,
	output logic is_zero
);
	// Increment or inclusive OR, zero detect on result
	always_comb begin
		case (op)
			ISOI_OP_INC: result = file_val + ISOI_ONE;
			ISOI_OP_ORL: result = w_val | lit_val;
			ISOI_OP_ORF: result = w_val | file_val;
			default: result = w_val;
		endcase
		is_zero = (result == ISOI_ZERO);
	end
endmodule // isoi_alu

// >>> verification/increment_skip_and_or_instructions_bench.sv
// Self-checking bench for the increment-skip and inclusive OR block.
// Assumes the bench stands in for the register file via file_rdata.
`timescale 1ns/10ps
module increment_skip_and_or_instructions_bench;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [13:0] instr = 14'h0000;
	logic [7:0] file_rdata = 8'h00;
	logic [6:0] file_addr;
	logic [7:0] file_wdata;
	logic [7:0] w_reg;
	logic file_we, zero_flag, zero_we, pc_advance, cycle_q4;
	logic no_operation_cycle;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	localparam int LIMIT = 400;

	isoi_core u_isoi_core (.sys_clk(sys_clk), .nrst(nrst), .instr(instr),
		.file_rdata(file_rdata), .file_addr(file_addr),
		.file_wdata(file_wdata), .file_we(file_we), .w_reg(w_reg),
		.zero_flag(zero_flag), .zero_we(zero_we), .pc_advance(pc_advance),
		.cycle_q4(cycle_q4), .no_operation_cycle(no_operation_cycle));

	// Clock at 10 MHz
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end

	// Hang guard; the tests need well under a hundred cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			close_out();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// One instruction cycle: word in before Q1, results read after Q4
	task automatic exec(input logic [13:0] word, input logic [7:0] rd);
		instr = word;
		file_rdata = rd;
		@(negedge sys_clk);
		chk(8'(cycle_q4), 8'h00);
		chk(8'(no_operation_cycle), 8'h00);
		repeat (3) @(negedge sys_clk);
		chk(8'(pc_advance), 8'h01);
		chk(8'(cycle_q4), 8'h01);
	endtask

	// Offer a word that would set W to FF if it were not dropped
	task automatic skipped(input logic [7:0] w_keep);
		instr = 14'h38FF;
		@(negedge sys_clk);
		chk(8'(no_operation_cycle), 8'h01);
		repeat (3) @(negedge sys_clk);
		chk(w_reg, w_keep);
		chk(8'(file_we), 8'h00);
		chk(8'(zero_we), 8'h00);
	endtask

	task automatic t_or_file();
		exec(14'h0413, 8'h00);
		chk(w_reg, 8'h00);
		chk(8'(zero_we), 8'h01);
		chk(8'(zero_flag), 8'h01);
		exec(14'h04FF, 8'h40);
		chk(8'(file_addr), 8'h7F);
		chk(file_wdata, 8'h40);
		chk(8'(file_we), 8'h01);
		chk(w_reg, 8'h00);
		chk(8'(zero_flag), 8'h00);
		$display("or with file done");
	endtask

	task automatic t_or_lit();
		exec(14'h389A, 8'h55); // Stray read data must not leak in
		chk(w_reg, 8'h9A);
		exec(14'h3835, 8'h00);
		chk(w_reg, 8'hBF);
		chk(8'(zero_we), 8'h01);
		chk(8'(zero_flag), 8'h00);
		chk(8'(file_we), 8'h00);
		$display("or literal done");
	endtask

	task automatic t_inc_step();
		exec(14'h0F05, 8'h41);
		chk(w_reg, 8'h42);
		chk(8'(file_we), 8'h00);
		chk(8'(zero_we), 8'h00);
		exec(14'h0F85, 8'h7E);
		chk(file_wdata, 8'h7F);
		chk(8'(file_we), 8'h01);
		exec(14'h3800, 8'h00); // Must run, not be skipped
		chk(8'(zero_we), 8'h01);
		chk(w_reg, 8'h42);
		$display("increment without skip done");
	endtask

	task automatic t_inc_skip();
		exec(14'h0F85, 8'hFF);
		chk(file_wdata, 8'h00);
		chk(8'(file_we), 8'h01);
		chk(8'(zero_we), 8'h00);
		skipped(8'h42);
		exec(14'h3801, 8'h00);
		chk(w_reg, 8'h43);
		exec(14'h0F05, 8'hFF);
		chk(w_reg, 8'h00);
		skipped(8'h00);
		$display("increment with skip done");
	endtask

	// Main sequence; reset values of W and Z are the chosen zeros
	initial begin
		repeat (12) @(negedge sys_clk);
		chk(w_reg, 8'h00);
		chk(8'(zero_flag), 8'h00);
		nrst = 1'b1;
		t_or_file();
		t_or_lit();
		t_inc_step();
		t_inc_skip();
		close_out();
	end
endmodule // increment_skip_and_or_instructions_bench
